//--- logic/tob_order_buffering.v
// Order intake, program cycle sequencing, digroup buffers, scanner bus parity.
// Assumes all inputs synchronous to ref_clk; far ends honour ready/valid.
`timescale 1ns/100ps
`include "tob_defines.vh"
module tob_order_buffering #(
    parameter NUM_DG   = `TOB_DG_NUM,
    parameter TICK_CYC = `TOB_TICK_CYC,
    parameter RECS     = `TOB_TIMING_RECS
) (
    // Clock, reset, enable
    input  wire                        ref_clk,
    input  wire                        rst_b,
    input  wire                        clkEn,
    // Orders from central processor on unit_address_bus
    input  wire                        orderValid,
    input  wire [`TOB_ORDER_W-1:0]     orderWord,
    output reg                         orderReady_r,
    output reg                         orderQueueFull_r,
    // Hopper drain by executor
    output reg                         hopValid_r,
    output reg [`TOB_ORDER_W-1:0]      hopOrder_r,
    output reg                         hopIsSlot_r,
    input  wire                        hopTake,
    // Digroup inbound: program fills, channel side drains
    input  wire [NUM_DG-1:0]           dgInValid,
    input  wire [NUM_DG*8-1:0]         dgInData,
    output reg  [NUM_DG-1:0]           dgInReady_r,
    output reg  [NUM_DG-1:0]           dgChValid_r,
    output reg  [NUM_DG*9-1:0]         dgChWord_r,
    input  wire [NUM_DG-1:0]           dgChTake,
    // Digroup outbound: channel side fills, program drains
    input  wire [NUM_DG-1:0]           dgOutValid,
    input  wire [NUM_DG*9-1:0]         dgOutWord,
    output reg  [NUM_DG-1:0]           dgOutReady_r,
    output reg                         reportValid_r,
    output reg  [7:0]                  reportData_r,
    output reg  [4:0]                  reportDg_r,
    output reg                         dgParityErr_r,
    input  wire [NUM_DG-1:0]           dgEquipped,
    // Scanner answer bus
    input  wire [15:0]                 scanData,
    input  wire                        identify,
    input  wire                        allWell,
    output reg  [15:0]                 scanDataOut_r,
    output reg                         busParity_r,
    output reg                         parityCheckReq_r,
    output reg                         allWellOut_r,
    // Controller state
    input  wire                        powerGood,
    input  wire [`TOB_OS_W-1:0]        osStateIn,
    input  wire                        osStateLoad,
    output reg  [`TOB_OS_W-1:0]        osState_r,
    output reg                         standbyUnpowered_r,
    // Cycle status
    output reg  [6:0]                  phase_r,
    output reg                         suspended_r
);
    // ------------------------------------------------------------
    // Order input queue
    // ------------------------------------------------------------
    wire                    oqReady;
    wire                    oqValid;
    wire [`TOB_ORDER_W-1:0] oqData;
    wire                    oqFull;
    reg                     oqPop;
    // Orders kept in arrival order, full refuses
    tob_fifo #(.WIDTH(`TOB_ORDER_W), .DEPTH(`TOB_IN_DEPTH), .AW(5)) uOrderQueue (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .inValid  (orderValid),
        .inReady  (oqReady),
        .inData   (orderWord),
        .outValid (oqValid),
        .outReady (oqPop),
        .outData  (oqData),
        .full     (oqFull),
        .level    ()
    );

    // ------------------------------------------------------------
    // Digroup buffers
    // ------------------------------------------------------------
    wire [NUM_DG-1:0]   inRdy;
    wire [NUM_DG-1:0]   chValid;
    wire [NUM_DG*9-1:0] chWord;
    wire [NUM_DG-1:0]   outRdy;
    wire [NUM_DG-1:0]   repValid;
    wire [NUM_DG*9-1:0] repWord;
    reg  [NUM_DG-1:0]   repPop;
    genvar g;
    generate
        for (g = 0; g < NUM_DG; g = g + 1) begin : gDg
            wire [7:0] d = dgInData[g*8 +: 8];
            // Inbound toward channel unit, eight bits plus even parity
            tob_fifo #(.WIDTH(9), .DEPTH(`TOB_DG_DEPTH), .AW(5)) uIn (
                .ref_clk  (ref_clk),
                .rst_b    (rst_b),
                .clkEn    (clkEn),
                .inValid  (dgInValid[g] & dgEquipped[g]),
                .inReady  (inRdy[g]),
                .inData   ({^d, d}),
                .outValid (chValid[g]),
                .outReady (dgChTake[g] & dgChValid_r[g]),
                .outData  (chWord[g*9 +: 9]),
                .full     (),
                .level    ()
            );
            // Outbound state reports toward the program
            tob_fifo #(.WIDTH(9), .DEPTH(`TOB_DG_DEPTH), .AW(5)) uOut (
                .ref_clk  (ref_clk),
                .rst_b    (rst_b),
                .clkEn    (clkEn),
                .inValid  (dgOutValid[g] & dgEquipped[g]),
                .inReady  (outRdy[g]),
                .inData   (dgOutWord[g*9 +: 9]),
                .outValid (repValid[g]),
                .outReady (repPop[g]),
                .outData  (repWord[g*9 +: 9]),
                .full     (),
                .level    ()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Program cycle
    // ------------------------------------------------------------
    localparam [6:0] PH_INIT   = 7'h01;
    localparam [6:0] PH_REPORT = 7'h02;
    localparam [6:0] PH_UNLOAD = 7'h04;
    localparam [6:0] PH_EXEC   = 7'h08;
    localparam [6:0] PH_TIMING = 7'h10;
    localparam [6:0] PH_SVC    = 7'h20;
    localparam [6:0] PH_BACK   = 7'h40;

    reg [31:0] tick_r;
    reg        tickHit;
    reg [4:0]  dgIdx_r;
    reg [2:0]  slotCnt_r;
    reg [3:0]  otherCnt_r;
    reg [15:0] recIdx_r;
    reg [`TOB_ORDER_W-1:0] hopMem_r [0:`TOB_HOP_SLOT+`TOB_HOP_OTHER-1];
    reg [3:0]  hopWr_r;
    reg [3:0]  hopRd_r;
    reg        reconf_r;
    reg [`TOB_OS_W-1:0] osSaved_r;

    wire       curRep = repValid[dgIdx_r];
    wire [8:0] curWord = repWord[dgIdx_r*9 +: 9];
    wire       isSlot = oqData[`TOB_SLOT_BIT];
    wire       isMaint = oqData[`TOB_MAINT_BIT];
    wire       hopFull = isSlot ? (slotCnt_r == `TOB_HOP_SLOT)
                                : (otherCnt_r == `TOB_HOP_OTHER);
    wire       stopUnload = hopFull | (isMaint & oqData[`TOB_HIPRI_BIT]);

    always @* begin
        tickHit = (tick_r == TICK_CYC - 1);
        repPop  = {NUM_DG{1'b0}};
        oqPop   = 1'b0;
        if ((phase_r == PH_REPORT || phase_r == PH_SVC) && curRep && !tickHit) begin
            repPop[dgIdx_r] = 1'b1;
        end
        if (phase_r == PH_UNLOAD && oqValid && !stopUnload && !tickHit) begin
            oqPop = 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_b) begin
            tick_r <= 32'h0000_0000;
            phase_r <= PH_INIT;
            dgIdx_r <= 5'h00;
            slotCnt_r <= 3'h0;
            otherCnt_r <= 4'h0;
            recIdx_r <= 16'h0000;
            hopWr_r <= 4'h0;
            hopRd_r <= 4'h0;
            reconf_r <= 1'b0;
            suspended_r <= 1'b0;
            hopValid_r <= 1'b0;
            hopOrder_r <= {`TOB_ORDER_W{1'b0}};
            hopIsSlot_r <= 1'b0;
            reportValid_r <= 1'b0;
            reportData_r <= 8'h00;
            reportDg_r <= 5'h00;
            dgParityErr_r <= 1'b0;
        end else if (clkEn) begin
            reportValid_r <= 1'b0;
            dgParityErr_r <= 1'b0;
            tick_r <= tickHit ? 32'h0000_0000 : tick_r + 32'h0000_0001;
            if (tickHit) begin
                phase_r <= PH_INIT;  // Restart every tick
                suspended_r <= 1'b0;
                hopValid_r <= 1'b0;
            end else begin
                case (phase_r)
                    PH_INIT: begin
                        dgIdx_r <= 5'h00;
                        slotCnt_r <= 3'h0;
                        otherCnt_r <= 4'h0;
                        hopWr_r <= 4'h0;
                        hopRd_r <= 4'h0;
                        reconf_r <= 1'b0;
                        recIdx_r <= 16'h0000;
                        phase_r <= PH_REPORT;  // Reports before unloading
                    end
                    PH_REPORT, PH_SVC: begin
                        if (curRep) begin
                            reportValid_r <= 1'b1;
                            reportData_r <= curWord[7:0];
                            reportDg_r <= dgIdx_r;
                            dgParityErr_r <= (^curWord) == 1'b1;  // Odd parity fails
                        end else if (dgIdx_r == NUM_DG - 1) begin
                            dgIdx_r <= 5'h00;
                            // Break to background after second service
                            phase_r <= (phase_r == PH_REPORT) ? PH_UNLOAD : PH_BACK;
                        end else begin
                            dgIdx_r <= dgIdx_r + 5'h01;
                        end
                    end
                    PH_UNLOAD: begin
                        if (oqValid && isMaint && oqData[`TOB_RECONF_BIT]) begin
                            reconf_r <= 1'b1;
                        end
                        if (oqPop) begin
                            // Decode type, store in hopper, flag execution
                            hopMem_r[hopWr_r] <= oqData;
                            hopWr_r <= hopWr_r + 4'h1;
                            if (isSlot) slotCnt_r <= slotCnt_r + 3'h1;
                            else otherCnt_r <= otherCnt_r + 4'h1;
                        end else begin
                            // Stop on full hopper or high priority maintenance
                            phase_r <= PH_EXEC;
                        end
                    end
                    PH_EXEC: begin
                        if (reconf_r) begin
                            suspended_r <= 1'b1;  // Hold until next tick
                        end else if (hopValid_r && !hopTake) begin
                            hopValid_r <= 1'b1;
                        end else if (hopRd_r != hopWr_r) begin
                            hopValid_r <= 1'b1;
                            hopOrder_r <= hopMem_r[hopRd_r];
                            hopIsSlot_r <= hopMem_r[hopRd_r][`TOB_SLOT_BIT];
                            hopRd_r <= hopRd_r + 4'h1;
                        end else begin
                            hopValid_r <= 1'b0;
                            phase_r <= PH_TIMING;
                        end
                    end
                    PH_TIMING: begin
                        // Visit every pulsing state record
                        if (recIdx_r == RECS - 1) begin
                            phase_r <= PH_SVC;
                        end else begin
                            recIdx_r <= recIdx_r + 16'h0001;
                        end
                    end
                    PH_BACK: begin
                        phase_r <= PH_BACK;
                    end
                    default: phase_r <= PH_INIT;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Scanner bus, controller state, registered handshakes
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            scanDataOut_r <= 16'h0000;
            busParity_r <= 1'b0;
            parityCheckReq_r <= 1'b0;
            allWellOut_r <= 1'b0;
            osState_r <= {`TOB_OS_W{1'b0}};
            osSaved_r <= {`TOB_OS_W{1'b0}};
            standbyUnpowered_r <= 1'b0;
            orderReady_r <= 1'b0;
            orderQueueFull_r <= 1'b0;
            dgInReady_r <= {NUM_DG{1'b0}};
            dgOutReady_r <= {NUM_DG{1'b0}};
            dgChValid_r <= {NUM_DG{1'b0}};
            dgChWord_r <= {(NUM_DG*9){1'b0}};
        end else if (clkEn) begin
            scanDataOut_r <= scanData;
            busParity_r <= identify & ~(^scanData);  // Pulse on even parity while identify is high
            parityCheckReq_r <= identify;
            allWellOut_r <= allWell;
            if (!powerGood) begin
                standbyUnpowered_r <= 1'b1;
                if (!standbyUnpowered_r) osSaved_r <= osState_r;
            end else if (standbyUnpowered_r) begin
                standbyUnpowered_r <= 1'b0;
                osState_r <= osSaved_r;  // Last state return
            end else if (osStateLoad) begin
                osState_r <= osStateIn;
            end
            orderReady_r <= oqReady & ~(orderValid & oqReady & ~oqPop & (oqFull));
            orderQueueFull_r <= oqFull;
            dgInReady_r <= inRdy & dgEquipped;
            dgOutReady_r <= outRdy & dgEquipped;
            dgChValid_r <= chValid & ~(dgChTake & dgChValid_r);
            dgChWord_r <= chWord;
        end
    end
endmodule

//--- include/tob_defines.vh
// Constants for the trunk order buffering block.
// Assumes a 25 MHz ref_clk; included by bare name.
// Operation
// - Orders are single 23-bit words on unit_address_bus
// - Orders held first-in first-out until taken
// - One queue control governs writes and reads
// - Each digroup buffer: two 32-word queues
// - Digroup words are eight data plus even parity
// - Inbound queue carries orders toward channel unit
// - Outbound queue carries trunk and controller states
// - Up to 20 digroups, one buffer each
// - Every 10 ms tick restarts the cycle
// - Change reports first, then order unloading
// - Decode order type, hopper it, flag execution
// - Unloading stops on full hopper or high priority maintenance
// - Reconfiguring maintenance order suspends until next cycle
// - Otherwise run timing lists over every record
// - Service buffers again, then background work
// - Unpowered standby resumes its prior out-of-service state
// - Scanner bus carries an all-well bit
// - Pulse parity bit when 16-bit parity even, only while identify is high
// - Pulse check request when identifying as circuit
// - Hopper holds four slot and eleven other orders
`ifndef TOB_DEFINES_VH
`define TOB_DEFINES_VH
`define TOB_ORDER_W       23
`define TOB_MAINT_BIT     17
`define TOB_SLOT_BIT      18
`define TOB_RECONF_BIT    16
`define TOB_HIPRI_BIT     15
`define TOB_DG_DATA_W     8
`define TOB_DG_DEPTH      32
`define TOB_DG_NUM        20
`define TOB_IN_DEPTH      32
`define TOB_HOP_SLOT      4
`define TOB_HOP_OTHER     11
`define TOB_CLK_MHZ       25
`define TOB_TICK_MS       10
`define TOB_TICK_CYC      (`TOB_TICK_MS * 1000 * `TOB_CLK_MHZ)
`define TOB_TIMING_RECS   16
`define TOB_OS_W          3
`endif

//--- logic/tob_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset, clock enable.
`timescale 1ns/100ps
module tob_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst_b,
    input  wire             clkEn,
    // Fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData,
    // Status
    output wire             full,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_r;
    reg [AW-1:0]    rdPtr_r;
    reg [AW:0]      cnt_r;
    wire            doWr = inValid & inReady;
    wire            doRd = outValid & outReady;

    assign full     = (cnt_r == DEPTH[AW:0]);
    assign inReady  = ~full;
    assign outValid = (cnt_r != {(AW+1){1'b0}});
    assign outData  = mem_r[rdPtr_r];
    assign level    = cnt_r;

    always @(posedge ref_clk) begin
        if (doWr && clkEn) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_b) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            cnt_r   <= {(AW+1){1'b0}};
        end else if (clkEn) begin
            if (doWr) begin
                wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
            end
            if (doWr && !doRd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (doRd && !doWr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

//--- tb/tob_order_buffering_chk.sv
// Port checks for the order buffering block.
// Assumes one ref_clk domain; bound below.
`timescale 1ns/100ps
module tob_chk #(
    parameter NUM_DG = 20
) (
    // Clock and reset
    input wire                ref_clk,
    input wire                rst_b,
    input wire                clkEn,
    // Scanner bus
    input wire [15:0]         scanData,
    input wire                identify,
    input wire                allWell,
    input wire [15:0]         scanDataOut_r,
    input wire                busParity_r,
    input wire                parityCheckReq_r,
    input wire                allWellOut_r,
    // Orders and digroups
    input wire                orderReady_r,
    input wire                orderQueueFull_r,
    input wire                hopValid_r,
    input wire [22:0]         hopOrder_r,
    input wire                hopIsSlot_r,
    input wire                hopTake,
    input wire [NUM_DG-1:0]   dgChValid_r,
    input wire [NUM_DG*9-1:0] dgChWord_r,
    input wire                reportValid_r,
    input wire                dgParityErr_r,
    input wire [6:0]          phase_r,
    input wire                suspended_r
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_parity_bit: assert property (clkEn |=> busParity_r ==
        ($past(identify) & ~^$past(scanData))) else $error("bus parity bit wrong");
    chk_check_req: assert property (clkEn |=> parityCheckReq_r == $past(identify))
        else $error("check request wrong");
    chk_all_well: assert property (clkEn |=> allWellOut_r == $past(allWell) &&
        scanDataOut_r == $past(scanData)) else $error("scanner word wrong");
    chk_err_report: assert property (dgParityErr_r |-> reportValid_r)
        else $error("parity error without report");
    chk_phase_onehot: assert property ($onehot(phase_r))
        else $error("phase not one-hot");
    chk_reports_first: assert property ($rose(phase_r[2]) |-> $past(phase_r[1]))
        else $error("unload not after reports");
    chk_full_ready: assert property (orderQueueFull_r |-> !orderReady_r)
        else $error("ready while full");
    chk_hop_stands: assert property (hopValid_r && !hopTake && clkEn |=>
        (hopValid_r && $stable(hopOrder_r)) || phase_r[0]) else $error("hopper order dropped");
    chk_slot_type: assert property (hopValid_r |-> hopIsSlot_r == hopOrder_r[18])
        else $error("slot type wrong");
    chk_dg_even: assert property (dgChValid_r[0] |-> !(^dgChWord_r[8:0]))
        else $error("digroup word parity odd");
    cover property (hopValid_r && hopTake);
    cover property (dgParityErr_r);
    cover property (orderQueueFull_r);
    cover property ($rose(suspended_r));
endmodule
bind tob_order_buffering tob_chk #(.NUM_DG(NUM_DG)) chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .scanData(scanData),
    .identify(identify), .allWell(allWell), .scanDataOut_r(scanDataOut_r),
    .busParity_r(busParity_r), .parityCheckReq_r(parityCheckReq_r),
    .allWellOut_r(allWellOut_r), .orderReady_r(orderReady_r),
    .orderQueueFull_r(orderQueueFull_r), .hopValid_r(hopValid_r),
    .hopOrder_r(hopOrder_r), .hopIsSlot_r(hopIsSlot_r), .hopTake(hopTake),
    .dgChValid_r(dgChValid_r), .dgChWord_r(dgChWord_r), .reportValid_r(reportValid_r),
    .dgParityErr_r(dgParityErr_r), .phase_r(phase_r), .suspended_r(suspended_r)
);

//--- tb/tob_dg_model.sv
// Digroup controller model for lane 0.
// Assumes the bench sets stall and calls send.
`timescale 1ns/100ps
module tob_dg_model (
    // Clock
    input wire         ref_clk,
    // Inbound drain
    input wire         chValid,
    input wire [8:0]   chWord,
    output logic       chTake,
    // Outbound fill
    output logic       outValid,
    output logic [8:0] outWord
);
    logic       stall;
    logic [8:0] rx[$];
    initial {chTake, outValid, outWord, stall} = {2'b00, 9'h155, 1'b0};
    // Takes each offered word unless stalled
    always @(negedge ref_clk) begin
        if (chTake)
            chTake <= 1'b0;
        else if (chValid && !stall) begin
            rx.push_back(chWord);
            chTake <= 1'b1;
        end
    end
    // Offers one word, then turns the line over
    task send(input logic [7:0] b, input logic bad);
        @(negedge ref_clk);
        outWord = {^b ^ bad, b};
        outValid = 1'b1;
        @(negedge ref_clk);
        outValid = 1'b0;
        outWord = ~outWord;
    endtask
endmodule

//--- tb/test_tob_order_buffering.sv
// Self-checking bench for the order buffering block.
// Assumes design, checker and model compiled first.
`timescale 1ns/100ps
`include "tob_defines.vh"
module test_tob_order_buffering;
    localparam NDG  = 20;
    localparam TICK = 400;
    logic                    ref_clk, rst_b, clkEn, orderValid, identify, allWell;
    logic                    hopTake, powerGood, osStateLoad;
    logic [`TOB_ORDER_W-1:0] orderWord;
    logic [NDG-1:0]          dgInValid;
    logic [NDG*8-1:0]        dgInData;
    logic [15:0]             scanData;
    logic [2:0]              osStateIn;
    wire                     orderReady_r, orderQueueFull_r, hopValid_r, hopIsSlot_r;
    wire                     reportValid_r, dgParityErr_r, busParity_r, parityCheckReq_r;
    wire                     allWellOut_r, standbyUnpowered_r, suspended_r, pTake, pOv;
    wire [22:0]              hopOrder_r;
    wire [NDG-1:0]           dgInReady_r, dgChValid_r, dgOutReady_r;
    wire [NDG*9-1:0]         dgChWord_r;
    wire [7:0]               reportData_r;
    wire [4:0]               reportDg_r;
    wire [15:0]              scanDataOut_r;
    wire [2:0]               osState_r;
    wire [6:0]               phase_r;
    wire [8:0]               pOw;
    logic [22:0]             hq[$];
    int                      fails, comparisons;

    tob_order_buffering #(.NUM_DG(NDG), .TICK_CYC(TICK), .RECS(4)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .orderValid(orderValid),
        .orderWord(orderWord), .orderReady_r(orderReady_r),
        .orderQueueFull_r(orderQueueFull_r), .hopValid_r(hopValid_r),
        .hopOrder_r(hopOrder_r), .hopIsSlot_r(hopIsSlot_r), .hopTake(hopTake),
        .dgInValid(dgInValid), .dgInData(dgInData), .dgInReady_r(dgInReady_r),
        .dgChValid_r(dgChValid_r), .dgChWord_r(dgChWord_r), .dgChTake({19'h0, pTake}),
        .dgOutValid({19'h0, pOv}), .dgOutWord({171'h0, pOw}), .dgOutReady_r(dgOutReady_r),
        .reportValid_r(reportValid_r), .reportData_r(reportData_r),
        .reportDg_r(reportDg_r), .dgParityErr_r(dgParityErr_r),
        .dgEquipped(20'h00001), .scanData(scanData), .identify(identify),
        .allWell(allWell), .scanDataOut_r(scanDataOut_r), .busParity_r(busParity_r),
        .parityCheckReq_r(parityCheckReq_r), .allWellOut_r(allWellOut_r),
        .powerGood(powerGood), .osStateIn(osStateIn), .osStateLoad(osStateLoad),
        .osState_r(osState_r), .standbyUnpowered_r(standbyUnpowered_r),
        .phase_r(phase_r), .suspended_r(suspended_r)
    );
    tob_dg_model dg (
        .ref_clk(ref_clk), .chValid(dgChValid_r[0]), .chWord(dgChWord_r[8:0]),
        .chTake(pTake), .outValid(pOv), .outWord(pOw)
    );

    always #20 ref_clk = ~ref_clk;
    // Executor takes and logs each hopper order
    always @(negedge ref_clk) begin
        if (hopValid_r === 1'b1 && !hopTake)
            hq.push_back(hopOrder_r);
        hopTake <= hopValid_r === 1'b1 && !hopTake;
    end

    // ----
    // Helpers
    // ----
    task check(input logic [22:0] got, input logic [22:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function logic sig(int s);
        case (s)
            0: return reportValid_r;
            1: return suspended_r;
            2: return standbyUnpowered_r;
            default: return dg.rx.size() == 32;
        endcase
    endfunction
    task await(input int s, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sig(s) !== lvl && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        if (sig(s) !== lvl) begin
            check(0, 1, "timeout");
            conclude();
        end
    endtask

    // ----
    // Scenarios
    // ----
    task t_scan;
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            d = (16'h1357 * i[15:0]) ^ 16'h00f0;
            @(negedge ref_clk);
            scanData = d;
            identify = i[0];
            allWell = i[1];
            @(negedge ref_clk);
            check(busParity_r, i[0] & ~^d, "parity bit");
            check(parityCheckReq_r, i[0], "check request");
            check(allWellOut_r, i[1], "all well");
        end
        $display("scan done");
    endtask
    task t_power;
        @(negedge ref_clk);
        osStateIn = 3'h5;
        osStateLoad = 1;
        @(negedge ref_clk);
        osStateLoad = 0;
        powerGood = 0;
        await(2, 1, 20);
        powerGood = 1;
        await(2, 0, 20);
        check(osState_r, 3'h5, "state after power");
        $display("power done");
    endtask
    task t_dgfill;
        dg.stall = 1;
        for (int i = 0; i < 33; i++) begin
            @(negedge ref_clk);
            dgInValid = 20'h00003;
            dgInData[15:0] = {i[7:0], i[7:0]};
        end
        @(negedge ref_clk);
        dgInValid = 0;
        @(negedge ref_clk);
        check(dgInReady_r[0], 0, "inbound full");
        check(dgChValid_r[1], 0, "unequipped lane");
        dg.stall = 0;
        await(3, 1, 200);
        repeat (2) @(negedge ref_clk);
        check(dgChValid_r[0], 0, "inbound empty");
        for (int k = 0; k < 32; k++)
            check(dg.rx[k], {^k[7:0], k[7:0]}, "inbound word");
        $display("digroup fill done");
    endtask
    task t_report;
        for (int k = 0; k < 2; k++) begin
            dg.send(8'h3c ^ k[7:0], k[0]);
            await(0, 1, 3 * TICK);
            check(reportData_r, 8'h3c ^ k[7:0], "report data");
            check(reportDg_r, 0, "report lane");
            check(dgParityErr_r, k[0], "parity error");
            @(negedge ref_clk);
        end
        $display("report done");
    endtask
    task t_orders;
        int i;
        hq.delete();
        i = 0;
        @(negedge ref_clk);
        while (orderQueueFull_r !== 1'b1 && i < 64) begin
            orderValid = 1;
            orderWord = i[22:0];
            i++;
            @(negedge ref_clk);
        end
        orderValid = 0;
        check(orderQueueFull_r, 1, "order queue full");
        for (int n = 0; n < 6 * TICK && hq.size() < i - 1; n++)
            @(negedge ref_clk);
        check(hq.size(), i - 1, "orders delivered");
        foreach (hq[k])
            check(hq[k], k[22:0], "order sequence");
        $display("orders done");
    endtask
    task t_maint;
        @(negedge ref_clk);
        orderValid = 1;
        orderWord = 23'h070000;
        @(negedge ref_clk);
        orderValid = 0;
        await(1, 1, 3 * TICK);
        check(suspended_r, 1, "suspend");
        await(1, 0, 2 * TICK);
        check(suspended_r, 0, "resume at tick");
        $display("maintenance done");
    endtask

    initial begin
        ref_clk = 0;
        rst_b = 0;
        clkEn = 1;
        orderValid = 0;
        orderWord = 0;
        dgInValid = 0;
        dgInData = 0;
        scanData = 0;
        identify = 0;
        allWell = 0;
        powerGood = 1;
        osStateIn = 0;
        osStateLoad = 0;
        repeat (12) @(negedge ref_clk);
        rst_b = 1;
        t_scan();
        t_power();
        t_dgfill();
        t_report();
        t_orders();
        t_maint();
        conclude();
    end
endmodule
